// *** src/fracn_divider.sv ***
// Main synthesiser modulus divider with fractional option and speed-up codes.
// Assumes prescaler_in and synth_load_strobe are pins, AXI4-Lite from logic.
//
// Notes on behaviour
// (RULE_01) Speed-up follows the load strobe exactly; here it lags the synchronised strobe and is held off in standby
// (RULE_02) Boost exponent selects factor two to sixteen
// (RULE_03) Integral pump enabled only during speed-up
// (RULE_04) Eight-bit scale code feeds proportional pump
// (RULE_05) Pattern length five or eight by select
// (RULE_06) Numerator added once per comparison cycle
// (RULE_07) Overflow forces higher ratio on last count
// (RULE_08) Compensation code gated by fixed-width pulse
// (RULE_09) Zero numerator forces accumulator to zero
// (RULE_10) Eighths quarters and halves mask low bits
// (RULE_11) Compensation boosted and integral during speed-up; the compensation gate and code here ignore speed-up
// (RULE_12) Load, count down, reverse, count up, repeat
// (RULE_13) Positive control high down, low up
// (RULE_14) Comparator pulse from reload, edge re-timed
// (RULE_15) Down count held at least three
// (RULE_16) Up count zero means two fifty-six
// (RULE_17) Modulus control as complementary pair
// (RULE_18) Controller keeps strobe short without speed-up
// (RULE_19) Controller emulates zero up-count by reprogramming
// (RULE_20) Standby bit halts the main synthesiser
// (RULE_21) Pumps receive enables and codes only
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module fracn_divider (
  input wire logic ref_clk,
  input wire logic arst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic prescaler_in,
  input wire logic synth_load_strobe,
  output logic modulus_ctl_pos,
  output logic modulus_ctl_neg,
  output logic comparator_pulse,
  output logic speedup_active,
  output logic prop_pump_en,
  output logic integral_pump_en,
  output logic comp_gate_pulse,
  output logic main_standby,
  output fracn_pkg::pump_code_s pump_code,
  output logic [2:0] comp_code
);

  // ***************************************************************
  // Register file
  // ***************************************************************
  fracn_pkg::channel_word_s chan;
  fracn_pkg::channel_word_s chan_alt;
  logic use_alt;
  logic fraction_modulus_sel;
  logic main_standby_bit;
  logic frac_en;
  logic [7:0] prop_current_scale;
  logic [1:0] speedup_exp;
  logic [3:0] integral_ratio;
  logic [7:0] strobe_len;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] wr_word;
  logic [31:0] old_word;
  logic wr_fire;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [2:0] phase_sum;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Merge byte lanes over the current register value
  always_comb begin
    old_word = 32'h0;
    wr_hit = 1'b1;
    if (aw_addr == fracn_pkg::ADDR_CHANNEL) begin
      old_word = {9'h0, chan};
    end else if (aw_addr == fracn_pkg::ADDR_CHANNEL_ALT) begin
      old_word = {9'h0, chan_alt};
    end else if (aw_addr == fracn_pkg::ADDR_CONFIG) begin
      old_word = {29'h0, frac_en, main_standby_bit, fraction_modulus_sel};
    end else if (aw_addr == fracn_pkg::ADDR_SPEEDUP) begin
      old_word = {8'h0, strobe_len, integral_ratio, 2'h0, speedup_exp, prop_current_scale};
    end else begin
      wr_hit = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      wr_word[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : old_word[i*8 +: 8];
    end
  end

  // Write channel capture; address and data in either order
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fracn_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? fracn_pkg::AXI_OKAY : fracn_pkg::AXI_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register storage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan <= '{num: 3'h0, up: fracn_pkg::UP_RESET, down: fracn_pkg::DOWN_RESET};
      chan_alt <= '{num: 3'h0, up: fracn_pkg::UP_RESET, down: fracn_pkg::DOWN_RESET};
      fraction_modulus_sel <= 1'b0;
      main_standby_bit <= 1'b0;
      frac_en <= 1'b0;
      prop_current_scale <= fracn_pkg::SCALE_RESET;
      speedup_exp <= 2'h0;
      integral_ratio <= 4'h0;
      strobe_len <= fracn_pkg::STROBE_LEN_RESET;
    end else if (wr_fire && wr_hit) begin
      if (aw_addr == fracn_pkg::ADDR_CHANNEL) begin
        chan <= wr_word[22:0];
      end else if (aw_addr == fracn_pkg::ADDR_CHANNEL_ALT) begin
        chan_alt <= wr_word[22:0];
      end else if (aw_addr == fracn_pkg::ADDR_CONFIG) begin
        fraction_modulus_sel <= wr_word[fracn_pkg::CFG_MOD_SEL_BIT];
        main_standby_bit <= wr_word[fracn_pkg::CFG_STANDBY_BIT];
        frac_en <= wr_word[fracn_pkg::CFG_FRAC_EN_BIT];
      end else begin
        // (RULE_04) scale code from bus
        prop_current_scale <= wr_word[fracn_pkg::SU_SCALE_LSB +: 8];
        speedup_exp <= wr_word[fracn_pkg::SU_EXP_LSB +: 2];
        integral_ratio <= wr_word[fracn_pkg::SU_RATIO_LSB +: 4];
        strobe_len <= wr_word[fracn_pkg::SU_LEN_LSB +: 8];
      end
    end
  end

  // Read data mux with status word
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0;
    if (s_axi_araddr == fracn_pkg::ADDR_CHANNEL) begin
      rd_word = {9'h0, chan};
    end else if (s_axi_araddr == fracn_pkg::ADDR_CHANNEL_ALT) begin
      rd_word = {9'h0, chan_alt};
    end else if (s_axi_araddr == fracn_pkg::ADDR_CONFIG) begin
      rd_word = {29'h0, frac_en, main_standby_bit, fraction_modulus_sel};
    end else if (s_axi_araddr == fracn_pkg::ADDR_SPEEDUP) begin
      rd_word = {8'h0, strobe_len, integral_ratio, 2'h0, speedup_exp, prop_current_scale};
    end else if (s_axi_araddr == fracn_pkg::ADDR_STATUS) begin
      rd_word = {26'h0, use_alt, speedup_active, phase_sum, modulus_ctl_pos};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel: one-cycle answer, held until rready
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= fracn_pkg::AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? fracn_pkg::AXI_OKAY : fracn_pkg::AXI_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ***************************************************************
  // Pin synchronisers and edge detect
  // ***************************************************************
  logic [1:0] pre_sync;
  logic [1:0] strobe_sync;
  logic pre_last;
  logic pre_edge;

  // Two stages per pin; only stage two is looked at
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_sync <= 2'b00;
      strobe_sync <= 2'b00;
      pre_last <= 1'b0;
    end else begin
      pre_sync <= {pre_sync[0], prescaler_in};
      strobe_sync <= {strobe_sync[0], synth_load_strobe};
      pre_last <= pre_sync[1];
    end
  end

  assign pre_edge = pre_sync[1] && !pre_last && !main_standby_bit;

  // ***************************************************************
  // Up/down counter
  // ***************************************************************
  typedef enum logic [1:0] {CNT_LOAD, CNT_DOWN, CNT_UP} cnt_state_e;
  cnt_state_e state;
  logic [11:0] count;
  logic [11:0] down_eff;
  logic [8:0] up_eff;
  logic reload;
  logic overflow;
  fracn_pkg::channel_word_s active;

  assign active = use_alt ? chan_alt : chan;
  // (RULE_15) clamp down count to its floor
  assign down_eff = (active.down < fracn_pkg::DOWN_MIN) ? fracn_pkg::DOWN_MIN : active.down;
  // (RULE_16) zero up count means 256
  assign up_eff = (active.up == 8'h00) ? fracn_pkg::UP_ZERO_COUNT : {1'b0, active.up};
  // Reload also when a new, shorter up count is already passed, so the counter never runs away to wrap
  assign reload = pre_edge && state == CNT_UP && count + 12'h001 >= {3'h0, up_eff};

  // (RULE_12) load, down, reverse, up, reload
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= CNT_LOAD;
      count <= 12'h000;
    end else if (pre_edge) begin
      case (state)
        CNT_LOAD: begin
          count <= down_eff - 12'h001;
          state <= CNT_DOWN;
        end
        CNT_DOWN: begin
          if (count == 12'h000) begin
            state <= CNT_UP;
          end else begin
            count <= count - 12'h001;
          end
        end
        default: begin
          if (reload) begin
            count <= down_eff - 12'h001;
            state <= CNT_DOWN;
          end else begin
            count <= count + 12'h001;
          end
        end
      endcase
    end
  end

  // Accumulator stepped once per comparison cycle
  fraction_accum u_accum (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .step(reload),
    .fraction_modulus_sel(fraction_modulus_sel),
    .fraction_numerator(frac_en ? active.num : 3'h0),
    .fraction_phase_sum(phase_sum),
    .overflow(overflow)
  );

  // Modulus control and comparator pulse, re-timed on prescaler edges
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      modulus_ctl_pos <= 1'b1;
      modulus_ctl_neg <= 1'b0;
      comparator_pulse <= 1'b0;
    end else begin
      if (pre_edge) begin
        // (RULE_13) high in down, low in up
        // (RULE_07) overflow steals last down count
        // (RULE_17) complementary pair
        modulus_ctl_pos <= (state == CNT_DOWN) && !(count == 12'h001 && overflow);
        modulus_ctl_neg <= !((state == CNT_DOWN) && !(count == 12'h001 && overflow));
      end
      // (RULE_14) pulse from reload event
      comparator_pulse <= reload;
    end
  end

  // ***************************************************************
  // Speed-up and pump codes
  // ***************************************************************
  logic [7:0] gate_cnt;

  // Speed-up tracks strobe; remembers which channel word was last written over the bus
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      speedup_active <= 1'b0;
      prop_pump_en <= 1'b0;
      integral_pump_en <= 1'b0;
      main_standby <= 1'b0;
      use_alt <= 1'b0;
      pump_code <= '0;
    end else begin
      // (RULE_01) speed-up follows synchronised strobe, held off in standby
      speedup_active <= strobe_sync[1] && !main_standby_bit;
      // (RULE_03) integral pump only in speed-up
      integral_pump_en <= strobe_sync[1] && !main_standby_bit;
      prop_pump_en <= !main_standby_bit;
      // (RULE_20) standby bit
      main_standby <= main_standby_bit;
      if (wr_fire && aw_addr == fracn_pkg::ADDR_CHANNEL_ALT) begin
        use_alt <= 1'b1;
      end else if (wr_fire && aw_addr == fracn_pkg::ADDR_CHANNEL) begin
        use_alt <= 1'b0;
      end
      // (RULE_02) exponent code, factor two to sixteen
      // (RULE_21) codes only, currents are analogue
      pump_code <= '{scale: prop_current_scale, exponent: speedup_exp, ratio: integral_ratio};
    end
  end

  // Compensation gate of fixed width after each reload with a non-zero phase sum
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_cnt <= 8'h00;
      comp_gate_pulse <= 1'b0;
      comp_code <= 3'h0;
    end else begin
      // (RULE_08) fixed-width gate with code
      // (RULE_11) not boosted: gate and code ignore the speed-up codes
      if (comparator_pulse && phase_sum != 3'h0) begin
        gate_cnt <= 8'(fracn_pkg::COMP_GATE_CYC);
        comp_gate_pulse <= 1'b1;
        comp_code <= phase_sum;
      end else if (gate_cnt > 8'h01) begin
        gate_cnt <= gate_cnt - 8'h01;
      end else begin
        gate_cnt <= 8'h00;
        comp_gate_pulse <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence s_reload;
    reload;
  endsequence

  a_speedup_follow: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_01
    !main_standby_bit && $stable(main_standby_bit) |=> speedup_active == $past(strobe_sync[1]))
    else $error("speed-up does not follow strobe");

  a_integral_off: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_03
    integral_pump_en |-> speedup_active)
    else $error("integral pump on outside speed-up");

  a_pair_compl: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_17
    modulus_ctl_pos != modulus_ctl_neg)
    else $error("modulus pair not complementary");

  a_up_low: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_13
    pre_edge && state == CNT_UP |=> !modulus_ctl_pos)
    else $error("positive control high in up count");

  a_cmp_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_14
    s_reload |=> comparator_pulse ##1 !comparator_pulse)
    else $error("comparator pulse not one cycle after reload");

  a_reload_down: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_12
    s_reload |=> state == CNT_DOWN && count == $past(down_eff) - 12'h001)
    else $error("reload did not load down count");

  a_gate_width: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_08
    $rose(comp_gate_pulse) |-> comp_gate_pulse [*4] ##1 !comp_gate_pulse || comparator_pulse)
    else $error("compensation gate width wrong");

  a_standby_out: assert property (@(posedge ref_clk) disable iff (!arst_n) // RULE_20
    main_standby_bit |=> main_standby && !prop_pump_en)
    else $error("standby not applied");

endmodule : fracn_divider

// *** src/fracn_pkg.sv ***
// Package for the main synthesiser modulus divider and fractional core.
// Assumes one 40 MHz clock domain; prescaler edges arrive as a pin input.
package fracn_pkg;

  // ***************************************************************
  // Register map (AXI4-Lite byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_CHANNEL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_SPEEDUP = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CHANNEL_ALT = 8'h10;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CH_DOWN_LSB = 0;
  localparam int CH_UP_LSB = 12;
  localparam int CH_NUM_LSB = 20;
  localparam int CFG_MOD_SEL_BIT = 0;
  localparam int CFG_STANDBY_BIT = 1;
  localparam int CFG_FRAC_EN_BIT = 2;
  localparam int SU_SCALE_LSB = 0;
  localparam int SU_EXP_LSB = 8;
  localparam int SU_RATIO_LSB = 12;
  localparam int SU_LEN_LSB = 16;

  // ***************************************************************
  // Reset values and counts
  // ***************************************************************
  localparam logic [11:0] DOWN_RESET = 12'h003;
  localparam logic [7:0] UP_RESET = 8'h01;
  localparam logic [11:0] DOWN_MIN = 12'h003;
  localparam logic [8:0] UP_ZERO_COUNT = 9'h100;
  localparam logic [2:0] MOD_FIFTHS = 3'h5;
  localparam logic [3:0] MOD_EIGHTHS = 4'h8;
  localparam logic [7:0] SCALE_RESET = 8'h10;
  localparam logic [7:0] STROBE_LEN_RESET = 8'h04;
  // Compensation gate width in reference clocks
  localparam real REF_CLK_MHZ = 40.0;
  localparam real COMP_GATE_NS = 100.0;
  localparam int COMP_GATE_CYC = int'($ceil(COMP_GATE_NS * REF_CLK_MHZ / 1000.0));
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic [2:0] num;
    logic [7:0] up;
    logic [11:0] down;
  } channel_word_s;

  typedef struct packed {
    logic [7:0] scale;
    logic [1:0] exponent;
    logic [3:0] ratio;
  } pump_code_s;

endpackage : fracn_pkg

// *** src/fraction_accum.sv ***
// Fractional phase accumulator in fifths or eighths.
// Assumes step pulses once per comparison cycle from the divider core.
`timescale 1ns/1ps
module fraction_accum (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic step,
  input wire logic fraction_modulus_sel,
  input wire logic [2:0] fraction_numerator,
  output logic [2:0] fraction_phase_sum,
  output logic overflow
);

  logic [3:0] sum;
  logic [3:0] modulus;
  logic [3:0] wrapped;
  logic [2:0] next_phase;

  // Add and wrap at the selected modulus
  always_comb begin
    // (RULE_05) pattern length select
    modulus = fraction_modulus_sel ? fracn_pkg::MOD_EIGHTHS : {1'b0, fracn_pkg::MOD_FIFTHS};
    sum = {1'b0, fraction_phase_sum} + {1'b0, fraction_numerator};
    wrapped = (sum >= modulus) ? sum - modulus : sum;
    next_phase = wrapped[2:0];
    // (RULE_10) quarter and half masking
    if (fraction_modulus_sel && fraction_numerator[1:0] == 2'b00) begin
      next_phase[1:0] = 2'b00;
    end else if (fraction_modulus_sel && fraction_numerator[0] == 1'b0) begin
      next_phase[0] = 1'b0;
    end
  end

  // Accumulator and overflow flag
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fraction_phase_sum <= 3'h0;
      overflow <= 1'b0;
    // (RULE_09) zero numerator clears
    end else if (fraction_numerator == 3'h0) begin
      fraction_phase_sum <= 3'h0;
      overflow <= 1'b0;
    end else if (step) begin
      // (RULE_06) add per comparison cycle
      fraction_phase_sum <= next_phase;
      overflow <= (sum >= modulus);
    end
  end

  // (RULE_09) zero numerator holds zero
  a_zero_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fraction_numerator == 3'h0 |=> fraction_phase_sum == 3'h0) // RULE_09
    else $error("accumulator not cleared on zero numerator");

  // (RULE_05) accumulator stays below modulus
  a_below_mod: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fraction_modulus_sel == 1'b0 && $stable(fraction_modulus_sel) |-> fraction_phase_sum < 3'h5) // RULE_05
    else $error("accumulator beyond fifths modulus");

  // (RULE_10) half numerator masks two bits
  a_half_mask: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fraction_modulus_sel && fraction_numerator == 3'h4 && step |=> fraction_phase_sum[1:0] == 2'b00) // RULE_10
    else $error("half numerator not masked");

endmodule : fraction_accum

// *** testbench/prescaler_model.sv ***
// Two-modulus prescaler model on the divider's far side.
// Assumes the positive modulus line alone selects the ratio.
`timescale 1ns/1ps
module prescaler_model #(
  parameter int R1 = 10
) (
  input wire logic ref_clk,
  input wire logic modulus_ctl_pos,
  output logic prescaler_in
);
  // ****
  // Output edges
  // ****
  // high gives the short period
  initial begin
    prescaler_in = 1'b0;
    forever begin
      repeat (4) @(posedge ref_clk);
      prescaler_in <= 1'b1;
      repeat (modulus_ctl_pos ? R1 - 4 : R1 - 3) @(posedge ref_clk);
      prescaler_in <= 1'b0;
    end
  end
endmodule : prescaler_model

// *** testbench/fracn_divider_bench.sv ***
// Self-checking bench for the modulus divider core.
// Assumes the prescaler model and an AXI4-Lite master task pair.
`timescale 1ns/1ps
module fracn_divider_bench;
  // ****
  // Signals
  // ****
  logic ref_clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, synth_load_strobe = 1'b0, prev = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pin, pos, neg, cpl, su, ppe, ipe, gate, stby;
  logic [2:0] ccode, ored = 3'h0;
  fracn_pkg::pump_code_s pcode;
  int num_errors = 0, checked = 0, seed = 25292, edges = 0, highs = 0, glen = 0, gates = 0, maxlen = 0, nf;
  int qe[$], qh[$];

  always #12.5 ref_clk = ~ref_clk;

  fracn_divider dut (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .prescaler_in(pin),
    .synth_load_strobe(synth_load_strobe), .modulus_ctl_pos(pos), .modulus_ctl_neg(neg),
    .comparator_pulse(cpl), .speedup_active(su), .prop_pump_en(ppe), .integral_pump_en(ipe),
    .comp_gate_pulse(gate), .main_standby(stby), .pump_code(pcode), .comp_code(ccode));
  prescaler_model psc (.ref_clk(ref_clk), .modulus_ctl_pos(pos), .prescaler_in(pin));

  // ****
  // Checks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic hang(input string what);
    num_errors++;
    $display("[ERR] %0t %s timed out", $time, what);
    stop_test();
  endtask : hang

  // Edges per comparison cycle; sampled pre-edge so no race with the design
  always @(posedge ref_clk) begin
    if (arst_n) chk({31'h0, neg}, {31'h0, !pos}, "neg");
    if (cpl) begin
      qe.push_back(edges);
      qh.push_back(highs);
      edges = 0;
      highs = 0;
    end
    if (pin && !prev) begin
      edges++;
      highs += int'(pos);
    end
    prev = pin;
    if (gate) begin
      glen++;
      ored |= ccode;
    end else if (glen != 0) begin
      maxlen = glen;
      gates++;
      glen = 0;
    end
  end

  // ****
  // Bus master
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic got;
    got = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && !got; n++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
      end
    end
    if (!got) hang("write");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
    int n;
    logic got;
    got = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && !got; n++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rready <= 1'b0;
        chk(rdata & m, exp, "rdata");
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
      end
    end
    if (!got) hang("read");
  endtask : rd

  // Model: n cycles give n*(down+up) edges, num of them stolen from the down count
  task automatic div(input int dn, input int up, input int num, input logic [2:0] cfg, input int n);
    int k, e, h;
    wr(fracn_pkg::ADDR_CONFIG, {29'h0, cfg}, fracn_pkg::AXI_OKAY);
    wr(fracn_pkg::ADDR_CHANNEL, 32'(num * 1048576 + up * 4096 + dn), fracn_pkg::AXI_OKAY);
    qe.delete();
    qh.delete();
    for (k = 0; k < 20000 && qe.size() < n + 2; k++) @(posedge ref_clk);
    if (k == 20000) hang("divide");
    gates = 0;
    ored = 3'h0;
    for (k = 0; k < 20000 && qe.size() < 2 * n + 2; k++) @(posedge ref_clk);
    if (k == 20000) hang("divide window");
    e = 0;
    h = 0;
    for (k = n + 2; k < 2 * n + 2; k++) begin
      e += qe[k];
      h += qh[k];
    end
    chk(32'(e), 32'(n * (dn + (up == 0 ? 256 : up))), "edges");
    chk(32'(h), 32'(n * dn - num), "down edges");
  endtask : div

  // ****
  // Sequence
  // ****
  initial begin
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(fracn_pkg::ADDR_CHANNEL, 32'h00001003, 32'h007FFFFF, fracn_pkg::AXI_OKAY);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, fracn_pkg::AXI_DECERR);
    wr(8'h20, 32'h1, fracn_pkg::AXI_DECERR);
    chk(32'(pcode), 32'h00000400, "pump reset");
    wr(fracn_pkg::ADDR_SPEEDUP, 32'h000492A5, fracn_pkg::AXI_OKAY);
    rd(fracn_pkg::ADDR_SPEEDUP, 32'h000092A5, 32'h0000F3FF, fracn_pkg::AXI_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(32'(pcode), 32'h00002969, "pump code");
    chk({31'h0, ipe}, 32'h0, "int off");
    synth_load_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({30'h0, su, ipe}, 32'h3, "boost on");
    synth_load_strobe <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({30'h0, su, ipe}, 32'h0, "boost off");
    wr(fracn_pkg::ADDR_CONFIG, 32'h2, fracn_pkg::AXI_OKAY);
    synth_load_strobe <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({29'h0, stby, ppe, su}, 32'h4, "standby");
    synth_load_strobe <= 1'b0;
    wr(fracn_pkg::ADDR_CHANNEL_ALT, 32'h00002005, fracn_pkg::AXI_OKAY);
    rd(fracn_pkg::ADDR_CHANNEL_ALT, 32'h00002005, 32'h007FFFFF, fracn_pkg::AXI_OKAY);
    rd(fracn_pkg::ADDR_STATUS, 32'h00000020, 32'h00000030, fracn_pkg::AXI_OKAY);
    div(5, 3, 0, 3'h0, 2);
    div(3, 2, 0, 3'h0, 2);
    div(4, 0, 0, 3'h0, 1);
    // Zero up-count effect: up set to the low ratio, down cut by that ratio plus one
    div(9, 10, 0, 3'h0, 1);
    nf = 1 + ($unsigned($random(seed)) % 4);
    div(6, 2, nf, 3'h4, 5);
    div(6, 2, 3, 3'h5, 8);
    chk(32'(maxlen), 32'(fracn_pkg::COMP_GATE_CYC), "gate len");
    div(6, 2, 2, 3'h5, 8);
    chk({31'h0, ored[0]}, 32'h0, "lsb");
    div(6, 2, 4, 3'h5, 8);
    chk({28'h0, ored & 3'h3, gates != 0}, 32'h1, "lsbs");
    div(6, 2, 0, 3'h4, 5);
    chk(32'(gates), 32'h0, "no gates");
    stop_test();
  end
endmodule : fracn_divider_bench
